//--- bdlc_host.sv
// bdlc_host: host-side model driving the byte register port.
// assumes a free running clock; the bench calls wr and rd.
`timescale 1ns/1ns
module bdlc_host (
  input wire logic clock,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic rvld
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rvld = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = (a == 8'h08) ? (d & 8'h77) : d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  // data is valid one edge after the address; rvld marks the sample edge
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    rvld = 1'b1;
    @(negedge clock);
    rvld = 1'b0;
  endtask
endmodule

//--- bdlc_pkg.sv
// bdlc_pkg: offsets, reset values, field positions and timing constants
// for the converter/regulator control register bank.
// assumes a 50 MHz core clock shared by every user of this package.
package bdlc_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] BDLC_OFS_MODE = 8'h04;
  localparam logic [7:0] BDLC_OFS_CTRL2 = 8'h05;
  localparam logic [7:0] BDLC_OFS_CORE = 8'h06;
  localparam logic [7:0] BDLC_OFS_SLEW = 8'h07;
  localparam logic [7:0] BDLC_OFS_REGSEL = 8'h08;

  // reset values
  localparam logic [7:0] BDLC_RST_MODE = 8'hB1;
  localparam logic [7:0] BDLC_RST_CTRL2 = 8'h40;
  localparam logic [7:0] BDLC_RST_SLEW = 8'h06;
  localparam logic [4:0] BDLC_CORE_DEF_LOW = 5'h14;
  localparam logic [4:0] BDLC_CORE_DEF_HIGH = 5'h1E;
  // regulator defaults per {reg_default_pin_b, reg_default_pin_a}:
  // entry n is {b_select, a_select}, three bits each
  localparam logic [23:0] BDLC_REGSEL_DEFAULTS = 24'h6C970A;

  // field positions
  localparam int BDLC_MODE_LOW_RIPPLE = 3;
  localparam int BDLC_MODE_FPWM_SYSTEM = 2;
  localparam int BDLC_MODE_FPWM_CORE = 1;
  localparam int BDLC_MODE_FPWM_MEMORY = 0;
  localparam int BDLC_CTRL2_GO = 7;
  localparam int BDLC_CTRL2_ADJ = 6;
  localparam int BDLC_DIS_SYSTEM = 2;
  localparam int BDLC_DIS_CORE = 1;
  localparam int BDLC_DIS_MEMORY = 0;
  localparam int BDLC_REGSEL_B_LSB = 4;
  localparam int BDLC_REGSEL_A_LSB = 0;

  // ramp timing: one code is 25 mV, slowest rate 0.225 mV/us
  localparam int BDLC_CLK_PERIOD_NS = 20;
  localparam int BDLC_STEP_UV = 25000;
  localparam int BDLC_SLOW_RATE_UV_PER_US = 225;
  localparam int BDLC_SLOW_STEP_NS =
    (BDLC_STEP_UV * 1000) / BDLC_SLOW_RATE_UV_PER_US;
  localparam int BDLC_SLOW_STEP_CYCLES =
    BDLC_SLOW_STEP_NS / BDLC_CLK_PERIOD_NS;
  localparam int BDLC_CNT_W = 13;
  localparam logic [2:0] BDLC_SLEW_IMMEDIATE = 3'h7;

  typedef enum logic [0:0] {BDLC_IDLE, BDLC_RAMP} bdlc_seq_state_t;

  typedef struct packed {
    bdlc_seq_state_t st;
    logic [4:0] code;
    logic [BDLC_CNT_W-1:0] cnt;
  } bdlc_seq_t;

  typedef struct packed {
    logic [7:0] mode;
    logic go;
    logic adj;
    logic [2:0] dis;
    logic [4:0] core;
    logic [2:0] slew;
    logic [2:0] sel_b;
    logic [2:0] sel_a;
    logic init;
    logic [7:0] rdata;
    logic [2:0] dis_act;
  } bdlc_regs_t;

endpackage

//--- bdlc_ramp.sv
// bdlc_ramp: steps the internal core code toward the target code.
// assumes the target and slew stay stable while run is high.
`timescale 1ns/1ns
module bdlc_ramp
  import bdlc_pkg::*;
#(
  parameter int unsigned SLOW_STEP = BDLC_SLOW_STEP_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [4:0] target,
  input wire logic [2:0] slew,
  input wire logic load,
  input wire logic [4:0] load_code,
  output logic [4:0] code,
  output logic done
);

  localparam logic [BDLC_CNT_W-1:0] SLOW_CNT = BDLC_CNT_W'(SLOW_STEP);

  bdlc_seq_t s_q;
  bdlc_seq_t s_d;
  logic [BDLC_CNT_W-1:0] period;

  // interval halves per slew step, so the rate doubles
  assign period = SLOW_CNT >> slew;
  assign code = s_q.code;
  // [RULE_06] done on code reached
  assign done = (s_q.st == BDLC_RAMP) && (s_q.code == target);

  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      BDLC_IDLE: begin
        if (run) begin
          s_d.st = BDLC_RAMP;
          s_d.cnt = period;
        end
      end
      BDLC_RAMP: begin
        if (!run || done) begin
          s_d.st = BDLC_IDLE;
        // [RULE_13] immediate code jump
        end else if (slew == BDLC_SLEW_IMMEDIATE) begin
          s_d.code = target;
        // [RULE_19] one code per interval
        end else if (s_q.cnt <= 13'h0001) begin
          s_d.cnt = period;
          if (s_q.code < target) begin
            s_d.code = s_q.code + 5'h01;
          end else begin
            s_d.code = s_q.code - 5'h01;
          end
        end else begin
          s_d.cnt = s_q.cnt - 13'h0001;
        end
      end
    endcase
    if (load) begin
      s_d.st = BDLC_IDLE;
      s_d.code = load_code;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: BDLC_IDLE, code: BDLC_CORE_DEF_LOW, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- bdlc_regs.sv
// bdlc_regs: control register bank for the step-down converters, the
// core-rail voltage change sequencer and the two auxiliary regulators.
// assumes a serial interface engine that presents one byte write per
// reg_wr pulse; reads are answered from reg_addr one cycle later.
//
// Behaviour
// [RULE_01] mode register at 04h, reset B1h, phase/ripple/forced PWM bits
// [RULE_02] bit 3 picks efficiency (0) or low-ripple (1) light-load mode
// [RULE_03] bits 2,1,0 force system, core, memory converters to PWM
// [RULE_04] control register 05h resets 40h; start clears on lockout/done
// [RULE_05] start bit ramps core to target code at selected slew rate
// [RULE_06] start clears once internal code reaches target, not regulation
// [RULE_07] adjust bit 0 uses register code, 1 uses default pin
// [RULE_08] adjust bit and core code restored on four reset events
// [RULE_09] bits 2..0 enable discharge of disabled system/core/memory rails
// [RULE_10] core code register 06h, 5 bits, default 14h or 1Eh by pin
// [RULE_11] codes step 25 mV from 0.8 V; all ones gives 1.575 V
// [RULE_12] slew register 07h, 3 bits, default 06h, reloaded on lockout
// [RULE_13] slew codes double rate from slowest; 111 applies immediately
// [RULE_14] regulator select register 08h; reserved bits 7 and 3 zero
// [RULE_15] lockout loads regulator selects from the two default pins
// [RULE_16] regulator b codes map 1.05 V up to 3.3 V
// [RULE_17] regulator a codes map 1 V up to 3.15 V
// [RULE_18] register-set core voltage ignores the default-pin divider
// [RULE_19] sequencer steps one code per slew-derived interval
// [RULE_20] host sets target and slew first, then polls start clear
`timescale 1ns/1ns
module bdlc_regs
  import bdlc_pkg::*;
#(
  parameter int unsigned SLOW_STEP_CYCLES = BDLC_SLOW_STEP_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic supply_lockout,
  input wire logic warm_reset_input_n,
  input wire logic power_on_reset_output,
  input wire logic backup_rail_low,
  input wire logic core_default_pin,
  input wire logic reg_default_pin_a,
  input wire logic reg_default_pin_b,
  input wire logic core_converter_en,
  input wire logic system_converter_en,
  input wire logic memory_converter_en,
  output logic [1:0] system_phase,
  output logic [1:0] memory_phase,
  output logic low_ripple,
  output logic force_fixed_freq_core,
  output logic force_fixed_freq_system,
  output logic force_fixed_freq_memory,
  output logic core_output_discharge,
  output logic system_output_discharge,
  output logic memory_output_discharge,
  output logic core_voltage_from_pin,
  output logic [4:0] core_rail_code,
  output logic dynamic_voltage_change_busy,
  output logic [2:0] reg_a_select,
  output logic [2:0] reg_b_select
);

  bdlc_regs_t r_q;
  bdlc_regs_t r_d;
  logic core_reset;
  logic [4:0] core_def;
  logic [5:0] sel_def;
  logic [4:0] ramp_code;
  logic ramp_done;
  logic ramp_load;

  // [RULE_08] any of four core reset events
  assign core_reset = supply_lockout || !warm_reset_input_n ||
                      power_on_reset_output || backup_rail_low;
  // [RULE_10] pin picks core default
  assign core_def = core_default_pin ? BDLC_CORE_DEF_HIGH : BDLC_CORE_DEF_LOW;
  // [RULE_15] defaults from the two pins
  assign sel_def = BDLC_REGSEL_DEFAULTS[
    {reg_default_pin_b, reg_default_pin_a} * 6 +: 6];
  // internal code follows the register default on every restore, so a
  // later start ramps from a known point
  assign ramp_load = core_reset || !r_q.init;

  bdlc_ramp #(
    .SLOW_STEP(SLOW_STEP_CYCLES)
  ) u_ramp (
    .clock(clock),
    .arst_n(arst_n),
    .run(r_q.go),
    .target(r_q.core),
    .slew(r_q.slew),
    .load(ramp_load),
    .load_code(core_def),
    .code(ramp_code),
    .done(ramp_done)
  );

  always_comb begin
    r_d = r_q;
    // [RULE_06] hardware clear on completion
    if (ramp_done) begin
      r_d.go = 1'b0;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        // [RULE_01] mode register write
        BDLC_OFS_MODE: r_d.mode = reg_wdata;
        BDLC_OFS_CTRL2: begin
          // [RULE_05] start request, wins over done
          r_d.go = reg_wdata[BDLC_CTRL2_GO];
          r_d.adj = reg_wdata[BDLC_CTRL2_ADJ];
          r_d.dis = reg_wdata[2:0];
        end
        BDLC_OFS_CORE: begin
          r_d.core = reg_wdata[4:0];
          // [RULE_18] register takes over from pin
          r_d.adj = 1'b0;
        end
        // [RULE_12] three-bit slew select
        BDLC_OFS_SLEW: r_d.slew = reg_wdata[2:0];
        BDLC_OFS_REGSEL: begin
          // [RULE_14] reserved bits not stored
          r_d.sel_b = reg_wdata[BDLC_REGSEL_B_LSB +: 3];
          r_d.sel_a = reg_wdata[BDLC_REGSEL_A_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
    // [RULE_08] restore adjust and core code
    if (core_reset || !r_q.init) begin
      r_d.adj = BDLC_RST_CTRL2[BDLC_CTRL2_ADJ];
      r_d.core = core_def;
    end
    if (supply_lockout || !r_q.init) begin
      r_d.mode = BDLC_RST_MODE;
      // [RULE_04] lockout clears start
      r_d.go = BDLC_RST_CTRL2[BDLC_CTRL2_GO];
      r_d.dis = BDLC_RST_CTRL2[2:0];
      // [RULE_12] slew reload on lockout
      r_d.slew = BDLC_RST_SLEW[2:0];
      // [RULE_15] pin-derived regulator defaults
      r_d.sel_b = sel_def[5:3];
      r_d.sel_a = sel_def[2:0];
    end
    r_d.init = 1'b1;
    // [RULE_09] discharge only while disabled
    r_d.dis_act[BDLC_DIS_SYSTEM] = r_q.dis[BDLC_DIS_SYSTEM] &&
                                   !system_converter_en;
    r_d.dis_act[BDLC_DIS_CORE] = r_q.dis[BDLC_DIS_CORE] &&
                                 !core_converter_en;
    r_d.dis_act[BDLC_DIS_MEMORY] = r_q.dis[BDLC_DIS_MEMORY] &&
                                   !memory_converter_en;
    unique case (reg_addr)
      BDLC_OFS_MODE: r_d.rdata = r_q.mode;
      BDLC_OFS_CTRL2: r_d.rdata = {r_q.go, r_q.adj, 3'h0, r_q.dis};
      // [RULE_10] upper bits read zero
      BDLC_OFS_CORE: r_d.rdata = {3'h0, r_q.core};
      BDLC_OFS_SLEW: r_d.rdata = {5'h00, r_q.slew};
      // [RULE_14] reserved bits read zero
      BDLC_OFS_REGSEL: r_d.rdata = {1'b0, r_q.sel_b, 1'b0, r_q.sel_a};
      default: r_d.rdata = 8'h00;
    endcase
  end

  // async reset gives constants only; pin defaults are taken on the
  // first edge after release through the init flag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '{mode: BDLC_RST_MODE,
               go: 1'b0,
               adj: 1'b1,
               dis: 3'h0,
               core: BDLC_CORE_DEF_LOW,
               slew: 3'h6,
               sel_b: 3'h0,
               sel_a: 3'h0,
               init: 1'b0,
               rdata: 8'h00,
               dis_act: 3'h0};
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign system_phase = r_q.mode[7:6];
  assign memory_phase = r_q.mode[5:4];
  // [RULE_02] shared light-load mode
  assign low_ripple = r_q.mode[BDLC_MODE_LOW_RIPPLE];
  // [RULE_03] per-converter forced PWM
  assign force_fixed_freq_system = r_q.mode[BDLC_MODE_FPWM_SYSTEM];
  assign force_fixed_freq_core = r_q.mode[BDLC_MODE_FPWM_CORE];
  assign force_fixed_freq_memory = r_q.mode[BDLC_MODE_FPWM_MEMORY];
  assign system_output_discharge = r_q.dis_act[BDLC_DIS_SYSTEM];
  assign core_output_discharge = r_q.dis_act[BDLC_DIS_CORE];
  assign memory_output_discharge = r_q.dis_act[BDLC_DIS_MEMORY];
  // [RULE_07] voltage source select
  assign core_voltage_from_pin = r_q.adj;
  // [RULE_11] code drives the analog dac; 0.8 V + 25 mV per step
  assign core_rail_code = ramp_code;
  assign dynamic_voltage_change_busy = r_q.go;
  // [RULE_16] b select to analog table
  assign reg_b_select = r_q.sel_b;
  // [RULE_17] a select to analog table
  assign reg_a_select = r_q.sel_a;

endmodule

//--- bdlc_regs_asserts.sv
// bdlc_regs_asserts: port-level properties of the register bank.
// assumes it is bound to bdlc_regs and sees only that module's ports.
`timescale 1ns/1ns
module bdlc_regs_asserts
  import bdlc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic supply_lockout,
  input wire logic warm_reset_input_n,
  input wire logic power_on_reset_output,
  input wire logic backup_rail_low,
  input wire logic core_converter_en,
  input wire logic low_ripple,
  input wire logic force_fixed_freq_core,
  input wire logic force_fixed_freq_system,
  input wire logic force_fixed_freq_memory,
  input wire logic core_output_discharge,
  input wire logic core_voltage_from_pin,
  input wire logic [4:0] core_rail_code,
  input wire logic dynamic_voltage_change_busy,
  input wire logic [2:0] reg_a_select,
  input wire logic [2:0] reg_b_select
);
  logic up_q;
  logic ev;
  logic [2:0] fpwm;
  assign ev = supply_lockout | ~warm_reset_input_n | power_on_reset_output
    | backup_rail_low;
  assign fpwm = {force_fixed_freq_system, force_fixed_freq_core,
    force_fixed_freq_memory};
  // the first edge after release loads pin defaults, so writes there lose
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  AST_LOW_RIPPLE: assert property (
    up_q && reg_wr && reg_addr == 8'h04 && !supply_lockout
    |=> low_ripple == $past(reg_wdata[3])) else $error("ripple bit wrong");
  AST_FPWM: assert property (
    up_q && reg_wr && reg_addr == 8'h04 && !supply_lockout
    |=> fpwm == $past(reg_wdata[2:0])) else $error("forced pwm wrong");
  AST_RDATA_MODE: assert property (
    up_q && !reg_wr && !supply_lockout && reg_addr == 8'h04
    |=> reg_rdata[3:0] == {low_ripple, fpwm}) else $error("mode readback");
  AST_GO_LOCK: assert property (
    up_q && supply_lockout |=> !dynamic_voltage_change_busy)
    else $error("start bit kept in lockout");
  AST_ADJ_EVENT: assert property (
    up_q && ev |=> core_voltage_from_pin) else $error("adjust not restored");
  AST_CORE_WR: assert property (
    up_q && !ev && reg_wr && reg_addr == 8'h06 |=> !core_voltage_from_pin)
    else $error("pin still selects core");
  AST_DIS_OFF: assert property (
    core_converter_en |=> !core_output_discharge)
    else $error("discharge while enabled");
  AST_REGSEL: assert property (
    up_q && !supply_lockout && reg_wr && reg_addr == 8'h08
    |=> {reg_b_select, reg_a_select} == $past({reg_wdata[6:4],
    reg_wdata[2:0]})) else $error("regulator select wrong");
  AST_RAIL_HOLD: assert property (
    up_q && !dynamic_voltage_change_busy && !ev && !$past(ev)
    |=> $stable(core_rail_code)) else $error("core code moved idle");
  cover property ($fell(dynamic_voltage_change_busy));
  cover property (core_output_discharge);
  cover property (up_q && ev);
endmodule
bind bdlc_regs bdlc_regs_asserts chk (.*);

//--- bdlc_regs_test.sv
// bdlc_regs_test: self-checking bench for the control register bank.
// assumes bdlc_host drives the register port; pins are driven here.
`timescale 1ns/1ns
module bdlc_regs_test;
  import bdlc_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr, rvld;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic supply_lockout = 1'b0;
  logic warm_reset_input_n = 1'b1;
  logic power_on_reset_output = 1'b0;
  logic backup_rail_low = 1'b0;
  logic core_default_pin = 1'b1;
  logic reg_default_pin_a = 1'b0;
  logic reg_default_pin_b = 1'b1;
  logic core_converter_en = 1'b1;
  logic system_converter_en = 1'b1;
  logic memory_converter_en = 1'b1;
  logic [1:0] system_phase, memory_phase;
  logic low_ripple, force_fixed_freq_core, force_fixed_freq_system;
  logic force_fixed_freq_memory, core_output_discharge;
  logic system_output_discharge, memory_output_discharge;
  logic core_voltage_from_pin, dynamic_voltage_change_busy;
  logic [4:0] core_rail_code;
  logic [2:0] reg_a_select, reg_b_select;
  logic [15:0] exq[$];
  logic [15:0] nt;
  logic [4:0] tg[8] = '{5'h10, 5'h1F, 5'h1C, 5'h00,
    5'h01, 5'h03, 5'h07, 5'h05};
  logic [2:0] sw[8] = '{3'h6, 3'h7, 3'h4, 3'h5, 3'h0, 3'h3, 3'h1, 3'h2};
  int errors = 0;
  int n_checks = 0;
  // 64 keeps the slowest step at 64 cycles so all slew codes fit the run
  bdlc_regs #(.SLOW_STEP_CYCLES(64)) uut (.*);
  bdlc_host host (.*);
  always #10 clock = ~clock;
  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exq.push_back({a, e});
    host.rd(a);
  endtask
  always @(posedge clock) begin
    if (rvld === 1'b1) begin
      nt = exq.pop_front();
      cmp($sformatf("reg %h", nt[15:8]), nt[7:0], reg_rdata);
    end
  end
  task automatic ramp(input logic [4:0] t, input logic [2:0] s);
    logic [4:0] p;
    int n;
    int lim;
    lim = ((t > core_rail_code) ? t - core_rail_code : core_rail_code - t)
      * (64 >> s);
    // target and slew first, then start, then poll
    host.wr(BDLC_OFS_CORE, {3'h0, t});
    host.wr(BDLC_OFS_SLEW, {5'h00, s});
    host.wr(BDLC_OFS_CTRL2, 8'h80);
    p = core_rail_code;
    n = 0;
    while (dynamic_voltage_change_busy === 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
      if (s != 3'h7 && core_rail_code !== p) begin
        cmp("step", 8'h01, 8'((p > core_rail_code) ? p - core_rail_code
          : core_rail_code - p));
      end
      p = core_rail_code;
    end
    cmp("rail", {3'h0, t}, {3'h0, core_rail_code});
    cmp("ramp time", 8'h01, 8'(n >= lim && n <= lim + 4));
    rdx(BDLC_OFS_CTRL2, 8'h00);
  endtask
  initial begin
    #1000000;
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(24));
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    rdx(BDLC_OFS_MODE, BDLC_RST_MODE);
    rdx(BDLC_OFS_CTRL2, BDLC_RST_CTRL2);
    rdx(BDLC_OFS_CORE, 8'h1E);
    rdx(BDLC_OFS_SLEW, BDLC_RST_SLEW);
    rdx(BDLC_OFS_REGSEL, 8'h11);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      host.wr(BDLC_OFS_MODE, v);
      cmp("ripple", {7'h0, v[3]}, {7'h0, low_ripple});
      cmp("phase", {4'h0, v[7:4]}, {4'h0, system_phase,
        memory_phase});
      cmp("fpwm", {5'h0, v[2:0]}, {5'h0, force_fixed_freq_system,
        force_fixed_freq_core, force_fixed_freq_memory});
      rdx(BDLC_OFS_MODE, v);
      host.wr(BDLC_OFS_SLEW, v);
      rdx(BDLC_OFS_SLEW, v & 8'h07);
      host.wr(BDLC_OFS_REGSEL, v);
      rdx(BDLC_OFS_REGSEL, v & 8'h77);
      cmp("sel", v & 8'h77, {1'b0, reg_b_select, 1'b0,
        reg_a_select});
      host.wr(8'h09 + 8'(i), v);
      rdx(8'h09 + 8'(i), 8'h00);
      {system_converter_en, core_converter_en, memory_converter_en} =
        3'($urandom);
      host.wr(BDLC_OFS_CTRL2, v & 8'h07);
      @(negedge clock);
      cmp("discharge", {5'h0, v[2:0] & ~{system_converter_en,
        core_converter_en, memory_converter_en}}, {5'h0,
        system_output_discharge, core_output_discharge,
        memory_output_discharge});
    end
    for (int i = 0; i < 8; i++) begin
      ramp(tg[i], sw[i]);
    end
    for (int k = 0; k < 3; k++) begin
      host.wr(BDLC_OFS_CORE, 8'h05);
      warm_reset_input_n = (k != 0);
      power_on_reset_output = (k == 1);
      backup_rail_low = (k == 2);
      repeat (2) @(negedge clock);
      {warm_reset_input_n, power_on_reset_output, backup_rail_low} = 3'b100;
      cmp("rail", 8'h1E, {3'h0, core_rail_code});
      cmp("pin", 8'h01, {7'h0, core_voltage_from_pin});
      rdx(BDLC_OFS_CORE, 8'h1E);
      rdx(BDLC_OFS_CTRL2, 8'h40);
    end
    host.wr(BDLC_OFS_SLEW, 8'h00);
    host.wr(BDLC_OFS_CORE, 8'h00);
    host.wr(BDLC_OFS_CTRL2, 8'h87);
    {core_default_pin, reg_default_pin_b, reg_default_pin_a} = 3'b001;
    supply_lockout = 1'b1;
    repeat (2) @(negedge clock);
    supply_lockout = 1'b0;
    cmp("busy", 8'h00, {7'h0, dynamic_voltage_change_busy});
    rdx(BDLC_OFS_MODE, BDLC_RST_MODE);
    rdx(BDLC_OFS_CTRL2, BDLC_RST_CTRL2);
    rdx(BDLC_OFS_CORE, 8'h14);
    rdx(BDLC_OFS_SLEW, BDLC_RST_SLEW);
    rdx(BDLC_OFS_REGSEL, 8'h34);
    repeat (3) @(negedge clock);
    final_report();
  end
endmodule
